// *** shared/sdirq_pkg.sv ***
package sdirq_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] DATA_LENGTH_OFS = 8'h28;
    localparam logic [7:0] DATA_CONTROL_OFS = 8'h2c;
    localparam logic [7:0] FLAG_STATUS_OFS = 8'h34;
    localparam logic [7:0] FLAG_CLEAR_OFS = 8'h38;
    localparam logic [7:0] IRQ_ENABLE_OFS = 8'h3c;
    localparam logic [7:0] WORD_COUNT_OFS = 8'h48;
    localparam logic [7:0] BUF_BASE_OFS = 8'h80;
    localparam logic [7:0] BUF_LAST_OFS = 8'hfc;

    // ----------------------------------------------------------------
    // Field layout and reset values
    // ----------------------------------------------------------------
    localparam int FLAG_W = 13;
    localparam int COUNT_W = 24;
    localparam int LEN_W = 25;
    localparam int XFER_EN_BIT = 0;
    localparam logic [12:0] IRQ_ENABLE_RST = 13'h0000;
    localparam logic [23:0] WORD_COUNT_RST = 24'h000000;
    localparam logic [31:0] BUF_WORD_RST = 32'h00000000;
    localparam logic [24:0] DATA_LENGTH_RST = 25'h0000000;

    typedef struct packed {
        logic tx_active_irq_en;
        logic cmd_active_irq_en;
        logic block_done_irq_en;
        logic start_bit_err_irq_en;
        logic transfer_done_irq_en;
        logic cmd_sent_irq_en;
        logic resp_received_irq_en;
        logic rx_overrun_irq_en;
        logic tx_underrun_irq_en;
        logic data_timeout_irq_en;
        logic cmd_timeout_irq_en;
        logic data_crc_fail_irq_en;
        logic cmd_crc_fail_irq_en;
    } sdirq_enable_s;

endpackage : sdirq_pkg

// *** hdl/sdirq_regs.sv ***
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/10ps
module sdirq_regs #(
    parameter int BUF_DEPTH = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [12:0] flag_set,
    input wire logic word_moved,
    output logic irq
);

    // ----------------------------------------------------------------
    // Bus address phase capture
    // ----------------------------------------------------------------
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic rd_hit;
    logic [31:0] rd_data_d;
    logic [31:0] rd_data_q;

    sdirq_pkg::sdirq_enable_s irq_enable;
    logic tx_active_irq_en_q;
    logic cmd_active_irq_en_q;
    logic block_done_irq_en_q;
    logic start_bit_err_irq_en_q;
    logic transfer_done_irq_en_q;
    logic cmd_sent_irq_en_q;
    logic resp_received_irq_en_q;
    logic rx_overrun_irq_en_q;
    logic tx_underrun_irq_en_q;
    logic data_timeout_irq_en_q;
    logic cmd_timeout_irq_en_q;
    logic data_crc_fail_irq_en_q;
    logic cmd_crc_fail_irq_en_q;
    logic enable_wr;
    logic [12:0] masked;
    logic [12:0] flags_q;
    logic [23:0] count_q;
    logic [24:0] length_q;
    logic xfer_en_q;
    logic [31:0] buf_q [BUF_DEPTH];
    logic irq_q;

    // Every word offset from the buffer base up to its last word lands in the window.
    function automatic logic in_buf(input logic [7:0] a);
        in_buf = (a >= sdirq_pkg::BUF_BASE_OFS) && (a <= sdirq_pkg::BUF_LAST_OFS);
    endfunction : in_buf

    function automatic logic [4:0] buf_idx(input logic [7:0] a);
        buf_idx = a[6:2];
    endfunction : buf_idx

    // One place decides that a pending data-phase write targets a given offset, except the counter load, which compares inline.
    function automatic logic hits(input logic pend, input logic [7:0] a, input logic [7:0] ofs);
        hits = pend && (a == ofs);
    endfunction : hits

    // Bytes to words, rounding a partial trailing word up.
    function automatic logic [23:0] words_of(input logic [24:0] len);
        logic [25:0] sum;
        sum = {1'b0, len} + 26'h0000003;
        words_of = sum[25:2];
    endfunction : words_of

    assign rd_hit = hsel && hready && htrans[1] && !hwrite;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= hsel && htrans[1] && hwrite;
            wr_addr_q <= haddr[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    always_comb begin
        rd_data_d = 32'h00000000;
        if (in_buf(haddr[7:0])) begin
            rd_data_d = buf_q[buf_idx(haddr[7:0])];
        end else begin
            case (haddr[7:0])
                sdirq_pkg::IRQ_ENABLE_OFS: rd_data_d = {19'h00000, irq_enable};
                sdirq_pkg::FLAG_STATUS_OFS: rd_data_d = {19'h00000, flags_q};
                sdirq_pkg::WORD_COUNT_OFS: rd_data_d = {8'h00, count_q};
                sdirq_pkg::DATA_LENGTH_OFS: rd_data_d = {7'h00, length_q};
                sdirq_pkg::DATA_CONTROL_OFS: rd_data_d = {31'h00000000, xfer_en_q};
                default: rd_data_d = 32'h00000000;
            endcase
        end
    end

    // Read data is registered, so every output is a flip-flop; no wait states.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_data_q <= 32'h00000000;
        end else if (rd_hit) begin
            rd_data_q <= rd_data_d;
        end
    end

    // No register needs a wait state, so the slave never stretches a transfer.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    assign hrdata = rd_data_q;

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // ----------------------------------------------------------------
    // Interrupt enable bits
    // ----------------------------------------------------------------
    // Enables only mask the request; flags keep collecting events while
    // masked, so setting an enable late raises the interrupt one clock after the enable loads.
    assign enable_wr = hits(wr_pend_q, wr_addr_q, sdirq_pkg::IRQ_ENABLE_OFS);

    assign irq_enable = {
        tx_active_irq_en_q,
        cmd_active_irq_en_q,
        block_done_irq_en_q,
        start_bit_err_irq_en_q,
        transfer_done_irq_en_q,
        cmd_sent_irq_en_q,
        resp_received_irq_en_q,
        rx_overrun_irq_en_q,
        tx_underrun_irq_en_q,
        data_timeout_irq_en_q,
        cmd_timeout_irq_en_q,
        data_crc_fail_irq_en_q,
        cmd_crc_fail_irq_en_q
    };

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_active_irq_en_q <= sdirq_pkg::IRQ_ENABLE_RST[12];
        end else if (enable_wr) begin
            tx_active_irq_en_q <= hwdata[12];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_active_irq_en_q <= sdirq_pkg::IRQ_ENABLE_RST[11];
        end else if (enable_wr) begin
            cmd_active_irq_en_q <= hwdata[11];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            block_done_irq_en_q <= sdirq_pkg::IRQ_ENABLE_RST[10];
        end else if (enable_wr) begin
            block_done_irq_en_q <= hwdata[10];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_bit_err_irq_en_q <= sdirq_pkg::IRQ_ENABLE_RST[9];
        end else if (enable_wr) begin
            start_bit_err_irq_en_q <= hwdata[9];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            transfer_done_irq_en_q <= sdirq_pkg::IRQ_ENABLE_RST[8];
        end else if (enable_wr) begin
            transfer_done_irq_en_q <= hwdata[8];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_sent_irq_en_q <= sdirq_pkg::IRQ_ENABLE_RST[7];
        end else if (enable_wr) begin
            cmd_sent_irq_en_q <= hwdata[7];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            resp_received_irq_en_q <= sdirq_pkg::IRQ_ENABLE_RST[6];
        end else if (enable_wr) begin
            resp_received_irq_en_q <= hwdata[6];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_overrun_irq_en_q <= sdirq_pkg::IRQ_ENABLE_RST[5];
        end else if (enable_wr) begin
            rx_overrun_irq_en_q <= hwdata[5];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_underrun_irq_en_q <= sdirq_pkg::IRQ_ENABLE_RST[4];
        end else if (enable_wr) begin
            tx_underrun_irq_en_q <= hwdata[4];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_timeout_irq_en_q <= sdirq_pkg::IRQ_ENABLE_RST[3];
        end else if (enable_wr) begin
            data_timeout_irq_en_q <= hwdata[3];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_timeout_irq_en_q <= sdirq_pkg::IRQ_ENABLE_RST[2];
        end else if (enable_wr) begin
            cmd_timeout_irq_en_q <= hwdata[2];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_crc_fail_irq_en_q <= sdirq_pkg::IRQ_ENABLE_RST[1];
        end else if (enable_wr) begin
            data_crc_fail_irq_en_q <= hwdata[1];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_crc_fail_irq_en_q <= sdirq_pkg::IRQ_ENABLE_RST[0];
        end else if (enable_wr) begin
            cmd_crc_fail_irq_en_q <= hwdata[0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            length_q <= sdirq_pkg::DATA_LENGTH_RST;
        end else if (hits(wr_pend_q, wr_addr_q, sdirq_pkg::DATA_LENGTH_OFS)) begin
            length_q <= hwdata[24:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xfer_en_q <= 1'b0;
        end else if (hits(wr_pend_q, wr_addr_q, sdirq_pkg::DATA_CONTROL_OFS)) begin
            xfer_en_q <= hwdata[sdirq_pkg::XFER_EN_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Status flags: a set in the same cycle as a clear wins.
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_q <= 13'h0000;
        end else if (hits(wr_pend_q, wr_addr_q, sdirq_pkg::FLAG_CLEAR_OFS)) begin
            flags_q <= (flags_q & ~hwdata[12:0]) | flag_set;
        end else begin
            flags_q <= flags_q | flag_set;
        end
    end

    // ----------------------------------------------------------------
    // Word counter
    // ----------------------------------------------------------------
    // Writing the enable bit loads the counter even if it was already set,
    // so software can restart a transfer without clearing first.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= sdirq_pkg::WORD_COUNT_RST;
        end else if (wr_pend_q && wr_addr_q == sdirq_pkg::DATA_CONTROL_OFS
                     && hwdata[sdirq_pkg::XFER_EN_BIT]) begin
            count_q <= words_of(length_q);
        end else if (word_moved && count_q != 24'h000000) begin
            // The counter halts at zero; a move pulse after the last word is
            // ignored rather than wrapping to the top of the range.
            count_q <= count_q - 24'h000001;
        end
    end

    // ----------------------------------------------------------------
    // Data buffer window
    // ----------------------------------------------------------------
    // The CPU and the core share one window; nothing here arbitrates, so
    // software must not touch a word the core is still moving.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < BUF_DEPTH; i++) begin
                buf_q[i] <= sdirq_pkg::BUF_WORD_RST;
            end
        end else if (wr_pend_q && in_buf(wr_addr_q)) begin
            buf_q[buf_idx(wr_addr_q)] <= hwdata;
        end
    end

    // ----------------------------------------------------------------
    // Masked flags
    // ----------------------------------------------------------------
    // Each flag is gated by its own enable before the OR, so a flag that
    // is masked can never hold the request up on its own.
    assign masked[12] = flags_q[12] & irq_enable.tx_active_irq_en;
    assign masked[11] = flags_q[11] & irq_enable.cmd_active_irq_en;
    assign masked[10] = flags_q[10] & irq_enable.block_done_irq_en;
    assign masked[9] = flags_q[9] & irq_enable.start_bit_err_irq_en;
    assign masked[8] = flags_q[8] & irq_enable.transfer_done_irq_en;
    assign masked[7] = flags_q[7] & irq_enable.cmd_sent_irq_en;
    assign masked[6] = flags_q[6] & irq_enable.resp_received_irq_en;
    assign masked[5] = flags_q[5] & irq_enable.rx_overrun_irq_en;
    assign masked[4] = flags_q[4] & irq_enable.tx_underrun_irq_en;
    assign masked[3] = flags_q[3] & irq_enable.data_timeout_irq_en;
    assign masked[2] = flags_q[2] & irq_enable.cmd_timeout_irq_en;
    assign masked[1] = flags_q[1] & irq_enable.data_crc_fail_irq_en;
    assign masked[0] = flags_q[0] & irq_enable.cmd_crc_fail_irq_en;

    // ----------------------------------------------------------------
    // Interrupt request
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |masked;
        end
    end

    assign irq = irq_q;

endmodule : sdirq_regs

// *** dv/sdirq_monitor.sv ***
`timescale 1ns/10ps
module sdirq_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [12:0] flag_set,
    input wire logic irq
);
    logic av_q, aw_q;
    logic [7:0] aa_q;
    logic [12:0] en_q, fl_q;
    wire logic wr = av_q & aw_q;
    wire logic rd = av_q & ~aw_q;
    // Shadow of enables and flags; a set pulse beats a clear in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {av_q, aw_q, aa_q, en_q, fl_q} <= '0;
        end else begin
            if (hready) {av_q, aw_q, aa_q} <= {hsel & htrans[1], hwrite, haddr[7:0]};
            if (wr && aa_q == 8'h3c) en_q <= hwdata[12:0];
            fl_q <= fl_q & ~((wr && aa_q == 8'h38) ? hwdata[12:0] : 13'h0) | flag_set;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_rd(a); rd && aa_q == a; endsequence
    a_ready_high: assert property (hreadyout) else $error("wait state seen");
    a_resp_okay: assert property (!hresp) else $error("error response seen");
    a_irq_follow: assert property (irq == $past(|(fl_q & en_q))) else $error("irq wrong");
    a_irq_masked: assert property (en_q == 13'h0 [*2] |-> !irq) else $error("irq unmasked");
    a_en_read: assert property (s_rd(8'h3c) |-> hrdata == {19'h0, en_q}) else $error("en");
    a_cnt_upper: assert property (s_rd(8'h48) |-> hrdata[31:24] == 8'h0) else $error("cnt");
    a_clr_zero: assert property (s_rd(8'h38) |-> hrdata == 32'h0) else $error("clr");
    a_unmapped_zero: assert property (s_rd(8'h00) |-> hrdata == 32'h0) else $error("hole");
endmodule : sdirq_monitor
bind sdirq_regs sdirq_monitor i_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .flag_set(flag_set), .irq(irq));

// *** dv/sdirq_core_model.sv ***
`timescale 1ns/10ps
module sdirq_core_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [12:0] flag_req,
    input wire logic move_req,
    output logic [12:0] flag_set,
    output logic word_moved
);
    // The core forwards each request one cycle late; a single-cycle request gives a single-cycle pulse, a held one a level.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) {flag_set, word_moved} <= 14'h0;
        else {flag_set, word_moved} <= {flag_req, move_req};
    end
endmodule : sdirq_core_model

// *** dv/sdirq_regs_test.sv ***
`timescale 1ns/10ps
module sdirq_regs_test;
    logic hclk, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp, irq, mv = 0, wm;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, bw [32];
    logic [12:0] fr = 0, fs;
    logic [24:0] len;
    logic [7:0] zr [4] = '{8'h00, 8'h38, 8'h3c, 8'h48};
    int mismatches = 0, check_count = 0;
    assign hready = hreadyout;
    sdirq_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .flag_set(fs),
        .word_moved(wm), .irq(irq));
    sdirq_core_model i_core (.hclk(hclk), .hresetn(hresetn), .flag_req(fr), .move_req(mv),
        .flag_set(fs), .word_moved(wm));
    initial begin
        hclk = 0;
        forever #5 hclk = ~hclk;
    end
    task automatic finish_test;
        if (mismatches == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    task automatic check(input string n, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : check
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {3'b110, w, 24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {3'b000, v};
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic pulse(input logic [12:0] f, input logic m);
        @(posedge hclk);
        {fr, mv} <= {f, m};
        @(posedge hclk);
        {fr, mv} <= 14'h0;
        repeat (3) @(posedge hclk);
    endtask : pulse
    function automatic logic [31:0] words(input logic [24:0] n);
        return ({7'h0, n} + 32'h3) >> 2;
    endfunction : words
    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        finish_test();
    end
    initial begin
        rd = $urandom(46);
        repeat (20) @(posedge hclk);
        hresetn <= 1;
        foreach (zr[i]) begin
            xfer(0, zr[i], 0);
            check("reset read", 0, rd);
        end
        foreach (bw[i]) begin
            xfer(0, 8'h80 + 8'(4 * i), 0);
            check("buffer reset", 0, rd);
            bw[i] = $urandom;
            xfer(1, 8'h80 + 8'(4 * i), bw[i]);
        end
        foreach (bw[i]) begin
            xfer(0, 8'h80 + 8'(4 * i), 0);
            check("buffer", bw[i], rd);
        end
        for (int i = 0; i < 13; i++) begin
            xfer(1, 8'h3c, 1 << i);
            pulse(~13'(1 << i), 0);
            check("irq masked", 0, irq);
            pulse(13'(1 << i), 0);
            check("irq enabled", 1, irq);
            xfer(0, 8'h34, 0);
            check("flag status", 32'h1fff, rd);
            xfer(1, 8'h38, 1 << i);
            repeat (2) @(posedge hclk);
            check("irq cleared", 0, irq);
            xfer(0, 8'h34, 0);
            check("flag clear", 32'h1fff ^ (1 << i), rd);
            xfer(1, 8'h38, 32'h1fff);
        end
        for (int i = 0; i < 9; i++) begin
            len = i < 6 ? 25'(i) : i < 8 ? 25'($urandom) : 25'h1ffffff;
            xfer(1, 8'h28, {7'h0, len});
            xfer(1, 8'h2c, 1);
            xfer(0, 8'h48, 0);
            check("count load", words(len), rd);
            pulse(0, 1);
            xfer(0, 8'h48, 0);
            check("count move", words(len) - (len != 0), rd);
        end
        finish_test();
    end
endmodule : sdirq_regs_test
